// file: hw/pll_vco_band_select_control.sv
/*
  Configuration logic for the on-chip PLL clock multiplier: loop and
  divider registers, PLL enable, manual or automatic VCO band selection
  and the lock status register.
  Assumes a register port from the serial configuration front end, with
  one-cycle write and read strobes synchronous to clock, and analog
  comparator and lock levels synchronous to clock.
*/
// Operation
// - Loop bandwidth and pump current, reset 0xE7
// - Sixty-four VCO bands, six-bit band value
// - Enable bit runs PLL as sample clock
// - Manual bit applies written band directly
// - Writes 0xC0 then 0x80 start auto search
// - Enable low: PLL off, direct clock pins
// - Lock indicator set once search ends locked
// - Sample clock is reference times loop ratio
`timescale 1ns/1ps
module pll_vco_band_select_control
  import pll_band_pkg::*;
#(
  parameter int SELECT_TIMEOUT_CYCLES = BAND_SELECT_CYCLES
)(
  // Clock and reset
  input  wire logic           clock,
  input  wire logic           resetn,
  input  wire logic           clock_enable,
  // Register port
  input  wire logic           reg_write,
  input  wire logic           reg_read,
  input  wire logic [7:0]     reg_address,
  input  wire logic [7:0]     reg_write_data,
  output logic      [7:0]     reg_read_data,
  // Analog PLL feedback
  input  wire logic           vco_fast,
  input  wire logic           pll_locked,
  // Analog PLL configuration
  output pll_config_type      pll_config
);

  localparam int TIMEOUT_WIDTH = $clog2(SELECT_TIMEOUT_CYCLES + 1);
  localparam logic [TIMEOUT_WIDTH-1:0] TIMEOUT_LAST = TIMEOUT_WIDTH'(SELECT_TIMEOUT_CYCLES - 1);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]               pll_control, next_pll_control;
  logic [7:0]               pll_loop_config, next_pll_loop_config;
  logic [7:0]               pll_divider_config, next_pll_divider_config;
  logic [7:0]               next_reg_read_data;
  logic                     select_timeout, next_select_timeout;
  logic [TIMEOUT_WIDTH-1:0] timeout_count, next_timeout_count;
  pll_config_type           next_pll_config;

  logic                     control_write;
  logic                     search_start;
  logic                     search_abort;
  logic                     search_busy;
  logic                     search_done;
  logic [BAND_WIDTH-1:0]    search_band;
  logic                     pll_enabled;
  logic                     manual_mode;
  logic                     lock_indicator;
  logic [BAND_WIDTH-1:0]    applied_band;

  // Search watchdog
  logic                     timeout_hit;
  logic                     search_stop;

  assign control_write = reg_write && (reg_address == ADDR_PLL_CONTROL);
  assign pll_enabled   = pll_control[CTRL_ENABLE_BIT];
  assign manual_mode   = pll_control[CTRL_MANUAL_BIT];

  // ----------------------------------------------------------------
  // Automatic band search control
  // ----------------------------------------------------------------
  // Start when the enabled PLL leaves manual mode, as 0xC0 then 0x80 does
  assign search_start = control_write && reg_write_data[CTRL_ENABLE_BIT]
                        && !reg_write_data[CTRL_MANUAL_BIT]
                        && pll_enabled && manual_mode;
  // Stop the search on a control write that disables or returns to manual
  assign search_abort = !search_start && control_write
                        && (!reg_write_data[CTRL_ENABLE_BIT] || reg_write_data[CTRL_MANUAL_BIT]);

  // Watchdog expiry on the last allowed busy cycle
  assign timeout_hit = search_busy && (timeout_count == TIMEOUT_LAST);

  // Abort outranks start inside the search, so expiry gives way to a restart
  assign search_stop = search_abort || (timeout_hit && !search_start);

  band_search u_band_search (
    .clock        (clock),
    .resetn       (resetn),
    .clock_enable (clock_enable),
    .start        (search_start),
    .abort        (search_stop),
    .vco_fast     (vco_fast),
    .band         (search_band),
    .busy         (search_busy),
    .done         (search_done)
  );

  // Manual field in manual mode, searched band otherwise
  assign applied_band = manual_mode ? pll_control[BAND_MSB:0] : search_band;

  // Lock shown only once the band in use is settled and locked
  assign lock_indicator = pll_enabled && pll_locked
                          && (manual_mode || search_done);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Write decode into the three configuration registers
  always_comb begin
    next_pll_control        = pll_control;
    next_pll_loop_config    = pll_loop_config;
    next_pll_divider_config = pll_divider_config;
    if (reg_write) begin
      case (reg_address)
        ADDR_PLL_CONTROL:        next_pll_control        = reg_write_data;
        ADDR_PLL_LOOP_CONFIG:    next_pll_loop_config    = reg_write_data;
        ADDR_PLL_DIVIDER_CONFIG: next_pll_divider_config = reg_write_data;
        default:                 next_pll_control        = pll_control;
      endcase
    end
  end

  // Registered configuration registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pll_control        <= PLL_CONTROL_RESET;
      pll_loop_config    <= LOOP_CONFIG_RESET;
      pll_divider_config <= DIVIDER_CONFIG_RESET;
    end else if (clock_enable) begin
      pll_control        <= next_pll_control;
      pll_loop_config    <= next_pll_loop_config;
      pll_divider_config <= next_pll_divider_config;
    end
  end

  // ----------------------------------------------------------------
  // Search watchdog
  // ----------------------------------------------------------------
  // Busy cycle count; an expiry sets the sticky flag even on a restart
  always_comb begin
    next_timeout_count  = timeout_count;
    next_select_timeout = select_timeout;
    if (search_start) begin
      next_timeout_count  = '0;
      next_select_timeout = timeout_hit;
    end else if (search_busy) begin
      next_timeout_count = timeout_count + TIMEOUT_WIDTH'(1);
      if (timeout_hit) begin
        next_select_timeout = 1'b1;
      end
    end
  end

  // Registered watchdog state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timeout_count  <= '0;
      select_timeout <= 1'b0;
    end else if (clock_enable) begin
      timeout_count  <= next_timeout_count;
      select_timeout <= next_select_timeout;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Read mux; unmapped offsets read zero
  always_comb begin
    next_reg_read_data = reg_read_data;
    if (reg_read) begin
      case (reg_address)
        ADDR_PLL_CONTROL:        next_reg_read_data = pll_control;
        ADDR_PLL_LOOP_CONFIG:    next_reg_read_data = pll_loop_config;
        ADDR_PLL_DIVIDER_CONFIG: next_reg_read_data = pll_divider_config;
        ADDR_PLL_STATUS:         next_reg_read_data = {lock_indicator, select_timeout,
                                                       applied_band};
        default:                 next_reg_read_data = 8'h00;
      endcase
    end
  end

  // Registered read data
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_read_data <= 8'h00;
    end else if (clock_enable) begin
      reg_read_data <= next_reg_read_data;
    end
  end

  // ----------------------------------------------------------------
  // Configuration toward the analog PLL
  // ----------------------------------------------------------------
  // Decode of the fields the analog PLL consumes
  always_comb begin
    next_pll_config.pll_enable         = pll_enabled;
    next_pll_config.use_pll_clock      = pll_enabled;
    next_pll_config.vco_band           = applied_band;
    next_pll_config.loop_bandwidth     = pll_loop_config[LOOP_BW_MSB:LOOP_BW_LSB];
    next_pll_config.pump_current       = pll_loop_config[PUMP_MSB:0];
    next_pll_config.cross_point_enable = pll_divider_config[DIV_CROSS_BIT];
    // Sample clock = reference x loop ratio; VCO = that x VCO ratio
    next_pll_config.loop_divide_ratio  =
      divide_ratio(pll_divider_config[DIV_LOOP_LSB +: 2], 1'b1);
    next_pll_config.vco_divide_ratio   =
      divide_ratio(pll_divider_config[DIV_VCO_LSB +: 2], 1'b0);
  end

  // Registered configuration outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pll_config <= '0;
    end else if (clock_enable) begin
      pll_config <= next_pll_config;
    end
  end

endmodule

// file: hw/pll_band_pkg.sv
/*
  Shared constants, types and helpers for the PLL clock multiplier
  configuration block: register offsets, field positions, reset values,
  timing counts and the configuration carrier.
  Assumes a 100 MHz configuration clock.
*/
package pll_band_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PLL_CONTROL        = 8'h12;
  localparam logic [7:0] ADDR_PLL_LOOP_CONFIG    = 8'h14;
  localparam logic [7:0] ADDR_PLL_DIVIDER_CONFIG = 8'h15;
  localparam logic [7:0] ADDR_PLL_STATUS         = 8'h16;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT    = 7;
  localparam int CTRL_MANUAL_BIT    = 6;
  localparam int BAND_MSB           = 5;
  localparam int LOOP_BW_MSB        = 7;
  localparam int LOOP_BW_LSB        = 5;
  localparam int PUMP_MSB           = 4;
  localparam int DIV_LOOP_LSB       = 0;
  localparam int DIV_VCO_LSB        = 2;
  localparam int DIV_CROSS_BIT      = 4;
  localparam int STATUS_LOCK_BIT    = 7;
  localparam int STATUS_TIMEOUT_BIT = 6;

  // ----------------------------------------------------------------
  // Reset values and command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] PLL_CONTROL_RESET    = 8'h00;
  localparam logic [7:0] LOOP_CONFIG_RESET    = 8'hE7;
  localparam logic [7:0] DIVIDER_CONFIG_RESET = 8'h00;
  localparam logic [7:0] AUTO_START_FIRST     = 8'hC0;
  localparam logic [7:0] AUTO_START_SECOND    = 8'h80;

  // ----------------------------------------------------------------
  // Band space and timing
  // ----------------------------------------------------------------
  localparam int BAND_COUNT          = 64;
  localparam int BAND_WIDTH          = $clog2(BAND_COUNT);
  localparam int CLOCK_PERIOD_NS     = 10;
  localparam int SETTLE_TIME_NS      = 2000;
  localparam int SETTLE_CYCLES       = (SETTLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int BAND_SELECT_TIME_MS = 10;
  localparam int BAND_SELECT_CYCLES  = (BAND_SELECT_TIME_MS * 1000000) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Configuration carrier toward the analog PLL
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  pll_enable;
    logic                  use_pll_clock;
    logic [BAND_WIDTH-1:0] vco_band;
    logic [2:0]            loop_bandwidth;
    logic [4:0]            pump_current;
    logic                  cross_point_enable;
    logic [4:0]            loop_divide_ratio;
    logic [4:0]            vco_divide_ratio;
  } pll_config_type;

  // Divider code to ratio; loop ratios start at 2, VCO ratios at 1
  function automatic logic [4:0] divide_ratio(input logic [1:0] code, input logic loop_divider);
    divide_ratio = loop_divider ? (5'h02 << code) : (5'h01 << code);
  endfunction

endpackage

// file: hw/band_search.sv
/*
  Successive-approximation VCO band search over the 6-bit band space.
  Assumes vco_fast is a settled comparator level, high while the VCO
  runs above the reference-derived target.
*/
`timescale 1ns/1ps
module band_search
  import pll_band_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic                  clock_enable,
  // Control
  input  wire logic                  start,
  input  wire logic                  abort,
  input  wire logic                  vco_fast,
  // Result
  output logic      [BAND_WIDTH-1:0] band,
  output logic                       busy,
  output logic                       done
);

  localparam int SETTLE_WIDTH = $clog2(SETTLE_CYCLES + 1);
  localparam logic [SETTLE_WIDTH-1:0] SETTLE_LAST = SETTLE_WIDTH'(SETTLE_CYCLES - 1);

  typedef enum logic [1:0] {IDLE, SETTLE, DECIDE} search_state_type;

  search_state_type          state, next_state;
  logic [BAND_WIDTH-1:0]     trial_bit, next_trial_bit;
  logic [BAND_WIDTH-1:0]     next_band;
  logic [SETTLE_WIDTH-1:0]   settle_count, next_settle_count;
  logic                      next_done;

  assign busy = (state != IDLE);

  // ----------------------------------------------------------------
  // Search sequencing
  // ----------------------------------------------------------------
  // Each step sets one trial bit, settles, then keeps or drops it
  always_comb begin
    next_state        = state;
    next_trial_bit    = trial_bit;
    next_band         = band;
    next_settle_count = settle_count;
    next_done         = done;
    if (abort) begin
      next_state = IDLE;
      next_done  = 1'b0;
    end else if (start) begin
      next_state        = SETTLE;
      next_trial_bit    = BAND_WIDTH'(1) << BAND_MSB;
      next_band         = BAND_WIDTH'(1) << BAND_MSB;
      next_settle_count = '0;
      next_done         = 1'b0;
    end else begin
      case (state)
        IDLE: begin
          next_state = IDLE;
        end
        SETTLE: begin
          next_settle_count = settle_count + SETTLE_WIDTH'(1);
          if (settle_count == SETTLE_LAST) begin
            next_state = DECIDE;
          end
        end
        DECIDE: begin
          // Too fast: drop this band bit
          if (vco_fast) begin
            next_band = band & ~trial_bit;
          end
          if (trial_bit[0]) begin
            next_state = IDLE;
            next_done  = 1'b1;
          end else begin
            next_trial_bit    = trial_bit >> 1;
            next_band         = (vco_fast ? (band & ~trial_bit) : band) | (trial_bit >> 1);
            next_settle_count = '0;
            next_state        = SETTLE;
          end
        end
        default: begin
          next_state = IDLE;
        end
      endcase
    end
  end

  // Registered search state
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state        <= IDLE;
      trial_bit    <= '0;
      band         <= '0;
      settle_count <= '0;
      done         <= 1'b0;
    end else if (clock_enable) begin
      state        <= next_state;
      trial_bit    <= next_trial_bit;
      band         <= next_band;
      settle_count <= next_settle_count;
      done         <= next_done;
    end
  end

endmodule

// file: test/pll_analog_model.sv
/*
  Behavioural analog PLL: comparator and lock detector.
  Assumes pll_config comes straight from the block under test.
*/
`timescale 1ns/1ps
module pll_analog_model
  import pll_band_pkg::*;
#(
  parameter logic [5:0] TARGET = 6'h2B
)(
  // Configuration in
  input  wire pll_config_type pll_config,
  // Feedback out
  output logic                vco_fast,
  output logic                pll_locked
);
  // ----------
  // Comparator and lock
  // ----------
  // VCO runs fast above the band that fits the target
  always_comb begin
    vco_fast   = pll_config.vco_band > TARGET;
    pll_locked = pll_config.pll_enable && (pll_config.vco_band == TARGET);
  end
endmodule

// file: test/pll_band_sva.sv
/*
  Port checker for the PLL band select control block.
  Assumes it is bound to the top module, single clock domain.
*/
`timescale 1ns/1ps
module pll_band_sva
  import pll_band_pkg::*;
#(
  parameter int SELECT_TIMEOUT_CYCLES = 2000
)(
  // Clock and reset
  input wire logic           clock,
  input wire logic           resetn,
  input wire logic           clock_enable,
  // Register port
  input wire logic           reg_write,
  input wire logic           reg_read,
  input wire logic [7:0]     reg_address,
  input wire logic [7:0]     reg_write_data,
  input wire logic [7:0]     reg_read_data,
  // Analog side
  input wire logic           vco_fast,
  input wire logic           pll_locked,
  input wire pll_config_type pll_config
);
  // ----------
  // Shadow of the control register
  // ----------
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;

  // Next control value on an accepted write
  always_comb begin
    next_ctrl = ctrl;
    if (clock_enable && reg_write && reg_address == 8'h12) begin
      next_ctrl = reg_write_data;
    end
  end

  // Register the shadow
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ----------
  // Properties
  // ----------
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // Write followed by two quiet cycles
  sequence s_wr(logic [7:0] a, logic c);
    clock_enable && reg_write && reg_address == a && c
    ##1 clock_enable && !reg_write ##1 clock_enable && !reg_write;
  endsequence

  a_clock_source: assert property (
    clock_enable |=> pll_config.use_pll_clock == $past(ctrl[7])
      && pll_config.pll_enable == $past(ctrl[7]))
    else $error("clock source differs from enable bit");
  a_enable_write: assert property (
    s_wr(8'h12, 1'b1) |=> pll_config.pll_enable == $past(reg_write_data[7], 3))
    else $error("enable bit not applied");
  a_manual_band: assert property (
    s_wr(8'h12, reg_write_data[6]) |=> pll_config.vco_band == $past(reg_write_data[5:0], 3))
    else $error("manual band not applied");
  a_loop_fields: assert property (
    s_wr(8'h14, 1'b1) |=> {pll_config.loop_bandwidth, pll_config.pump_current}
      == $past(reg_write_data, 3))
    else $error("loop fields not applied");
  a_reset_decode: assert property (
    $rose(resetn) |=> pll_config.loop_bandwidth == 3'b111 && pll_config.pump_current == 5'h07
      && !pll_config.pll_enable)
    else $error("reset decode wrong");
  a_divider_ratio: assert property (
    s_wr(8'h15, 1'b1) |=> pll_config.loop_divide_ratio == (5'h02 << $past(reg_write_data[1:0], 3))
      && pll_config.vco_divide_ratio == (5'h01 << $past(reg_write_data[3:2], 3)))
    else $error("divider ratio wrong");
  a_search_start: assert property (
    clock_enable && reg_write && reg_address == 8'h12 && reg_write_data[7:6] == 2'b10
      && ctrl[7:6] == 2'b11 |-> ##[2:4] pll_config.vco_band == 6'h20)
    else $error("search did not start at mid band");
  a_lock_manual: assert property (
    clock_enable && reg_read && reg_address == 8'h16 && ctrl[7:6] == 2'b11
      && pll_config.pll_enable |=> reg_read_data[7] == $past(pll_locked))
    else $error("lock status wrong in manual mode");

  // ----------
  // Coverage
  // ----------
  c_manual: cover property (s_wr(8'h12, reg_write_data[6]));
  c_start: cover property (reg_write && reg_write_data == 8'h95 && ctrl == 8'hC0);
  c_locked: cover property (reg_read && reg_address == 8'h16 ##1 reg_read_data[7]);
endmodule

// file: test/tb_pll_vco_band_select_control.sv
/*
  Self-checking bench for the PLL band select control block.
  Assumes the analog model and checker files are compiled first.
*/
`timescale 1ns/1ps
module tb_pll_vco_band_select_control
  import pll_band_pkg::*;
;
  // ----------
  // Signals
  // ----------
  logic           clock;
  logic           resetn;
  logic           clock_enable;
  logic           reg_write;
  logic           reg_read;
  logic [7:0]     reg_address;
  logic [7:0]     reg_write_data;
  logic [7:0]     reg_read_data;
  logic           vco_fast;
  logic           pll_locked;
  pll_config_type pll_config;
  int             num_errors;
  int             compares;
  int             cycles;

  pll_vco_band_select_control #(.SELECT_TIMEOUT_CYCLES(2000)) dut_u (
    .clock(clock), .resetn(resetn), .clock_enable(clock_enable),
    .reg_write(reg_write), .reg_read(reg_read), .reg_address(reg_address),
    .reg_write_data(reg_write_data), .reg_read_data(reg_read_data),
    .vco_fast(vco_fast), .pll_locked(pll_locked), .pll_config(pll_config));

  pll_analog_model #(.TARGET(6'h2B)) pll_u (
    .pll_config(pll_config), .vco_fast(vco_fast), .pll_locked(pll_locked));

  // ----------
  // Clock and watchdog
  // ----------
  // Free running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Cut a hang short
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      stop_test();
    end
  end

  // ----------
  // Tasks
  // ----------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_write = 1'b1;
    reg_address = a;
    reg_write_data = d;
    @(negedge clock);
    reg_write = 1'b0;
    repeat (2) @(negedge clock);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(negedge clock);
    reg_read = 1'b1;
    reg_address = a;
    @(negedge clock);
    reg_read = 1'b0;
    @(negedge clock);
    check(reg_read_data, exp, msg);
  endtask

  task automatic stop_test();
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic test_reset();
    rd(8'h12, 8'h00, "control reset");
    rd(8'h14, 8'hE7, "loop reset");
    rd(8'h15, 8'h00, "divider reset");
    rd(8'h30, 8'h00, "unmapped read");
    check({3'b000, pll_config.pump_current}, 8'h07, "pump reset");
  endtask

  task automatic test_loop();
    logic [1:0] c;
    wr(8'h14, 8'h55);
    rd(8'h14, 8'h55, "loop readback");
    check({5'h00, pll_config.loop_bandwidth}, 8'h02, "bandwidth");
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(8'h15, {3'b000, c == 2'd3, c, c});
      check({3'b000, pll_config.loop_divide_ratio}, 8'({5'h02 << c}), "loop ratio");
      check({3'b000, pll_config.vco_divide_ratio}, 8'({5'h01 << c}), "vco ratio");
      check({7'h00, pll_config.cross_point_enable}, {7'h00, c == 2'd3}, "cross");
    end
    wr(8'h14, 8'hE7);
    wr(8'h15, 8'h00);
  endtask

  task automatic test_manual();
    wr(8'h12, 8'h2B);
    wr(8'h12, 8'h6B);
    wr(8'h12, 8'hEB);
    check({2'b00, pll_config.vco_band}, 8'h2B, "manual band");
    check({6'h00, pll_config.pll_enable, pll_config.use_pll_clock}, 8'h03, "enable");
    rd(8'h16, 8'hAB, "manual lock");
    wr(8'h12, 8'hD0);
    rd(8'h16, 8'h10, "manual unlocked");
    wr(8'h12, 8'h40);
    check({6'h00, pll_config.pll_enable, pll_config.use_pll_clock}, 8'h00, "bypass");
  endtask

  task automatic test_auto();
    wr(8'h12, 8'hC0);
    wr(8'h12, 8'h95);
    check({2'b00, pll_config.vco_band}, 8'h20, "first trial band");
    rd(8'h16, 8'h20, "no lock during search");
    repeat (1300) @(negedge clock);
    rd(8'h16, 8'hAB, "search result locked");
    check({2'b00, pll_config.vco_band}, 8'h2B, "searched band used");
  endtask

  // Frozen clock enable ignores writes and reads; then a mid-run reset
  task automatic test_freeze();
    @(negedge clock);
    clock_enable = 1'b0;
    wr(8'h14, 8'h11);
    rd(8'h15, 8'hAB, "read data frozen");
    check({2'b00, pll_config.vco_band}, 8'h2B, "config frozen");
    @(negedge clock);
    clock_enable = 1'b1;
    rd(8'h14, 8'hE7, "write ignored while frozen");
    resetn = 1'b0;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    rd(8'h12, 8'h00, "control after reset");
    rd(8'h16, 8'h00, "status after reset");
    check({3'b000, pll_config.loop_divide_ratio}, 8'h02, "ratio after reset");
  endtask

  // ----------
  // Main sequence
  // ----------
  initial begin
    num_errors = 0;
    compares = 0;
    cycles = 0;
    resetn = 1'b0;
    clock_enable = 1'b1;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_address = 8'h00;
    reg_write_data = 8'h00;
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    test_reset();
    test_loop();
    test_manual();
    test_auto();
    test_freeze();
    stop_test();
  end
endmodule

bind pll_vco_band_select_control pll_band_sva #(
  .SELECT_TIMEOUT_CYCLES(SELECT_TIMEOUT_CYCLES)
) sva_u (
  .clock(clock), .resetn(resetn), .clock_enable(clock_enable),
  .reg_write(reg_write), .reg_read(reg_read), .reg_address(reg_address),
  .reg_write_data(reg_write_data), .reg_read_data(reg_read_data),
  .vco_fast(vco_fast), .pll_locked(pll_locked), .pll_config(pll_config));
